// *** src/seh_cmd_engine.sv ***
// Extended hub command engine: buffer, execute decode, port control.
// Assumes an upstream SMBus layer forwards transactions over Wishbone.
// Function
// - Execute request is offset word 993Eh followed by a zero byte.
// - Command code is taken from buffer offset zero.
// - Host zeroes status byte at offset one; engine writes completion there.
// - Slave address starts as one of two fixed values, picked by strap.
// - Bytes 99h, 3Eh then 00h start the buffered command.
// - Read returns count 128 then data; stop ends it cleanly anytime.
// - Command 00h loads slave address from offset two for later use.
// - Bit 7 of that parameter restores the factory default address.
// - Command 01h always returns fixed default address 2dh.
// - Command 02h returns configured flag in bit 7, hub address below.
// - Command 03h returns mask of ports with a charge controller.
// - First parameter is port mask; next five bytes hold port results.
// - Connect byte: bit 5 L2 suspend, bit 4 U3 suspend.
// - Connect byte: bit 1 legacy attach, bit 0 superspeed attach.
// - Command 81h reports one per masked port with power enabled.
// - Command 82h applies requested disable bytes to masked ports.
// - Disable bits 2:0 applied only when bit 7 of the byte is set.
// - Bit 2 power off, bit 1 superspeed and bit 0 legacy terms off.
// - Command 83h: bit 1 minus line high, bit 0 plus line high.
// - Command 84h reads charge controller register into second parameter.
`timescale 1ns/100ps
module seh_cmd_engine import seh_pkg::*; #(
    parameter int N        = NPORT,
    parameter int CC_WAIT  = CC_WAIT_CYC
) (
    input  wire logic               clk_in,
    input  wire logic               rstn_in,
    input  wire logic               wb_cyc_in,
    input  wire logic               wb_stb_in,
    input  wire logic               wb_we_in,
    input  wire logic [7:0]         wb_adr_in,
    input  wire logic [3:0]         wb_sel_in,
    input  wire logic [31:0]        wb_dat_in,
    output logic [31:0]             wb_dat_out,
    output logic                    wb_ack_out,
    input  wire logic               addr_strap_in,
    input  wire logic               hub_configured_in,
    input  wire logic [6:0]         legacy_hub_bus_addr_in,
    input  wire logic [N-1:0]       charge_controller_present_in,
    input  wire seh_port_stat_t [N-1:0] port_stat_in,
    output seh_port_dis_t [N-1:0]   port_dis_out,
    output logic [6:0]              slave_addr_out,
    output logic                    cc_rd_req_out,
    output logic [7:0]              cc_rd_addr_out,
    input  wire logic               cc_rd_ack_in,
    input  wire logic [7:0]         cc_rd_data_in,
    output logic                    busy_out
);
    seh_state_t         state_q;
    logic               ack_q;
    logic [31:0]        rdat_q;
    logic [15:0]        ptr_q;
    logic               first_q;
    logic [6:0]         dflt_q;
    logic [6:0]         addr_q;
    logic               strap_done_q;
    logic [2:0]         idx_q;
    logic [7:0]         status_q;
    logic [15:0]        wait_q;
    logic               req_q;
    logic [7:0]         ccad_q;
    logic [7:0][7:0]    head;
    logic [7:0]         rdata;
    logic [N-1:0][7:0]  fmt;
    logic               bus_req;
    logic               bus_wr;
    logic               bus_rd;
    logic               in_range;
    logic               bus_we;
    logic               start;
    logic               ex_we;
    logic [BUF_AW-1:0]  ex_addr;
    logic [7:0]         ex_data;
    logic               buf_we;
    logic [BUF_AW-1:0]  buf_addr;
    logic [7:0]         buf_data;
    logic [7:0]         cmd;
    logic [N-1:0]       mask;
    logic               port_cmd;

    assign bus_req  = wb_cyc_in && wb_stb_in && !ack_q;
    // Writes land on the edge that samples ack, never on the request edge
    assign bus_wr   = wb_cyc_in && wb_stb_in && wb_we_in && ack_q;
    assign bus_rd   = bus_req && !wb_we_in;
    assign in_range = ptr_q < 16'(BUF_DEPTH);
    assign cmd      = head[OFS_CMD];
    assign mask     = head[OFS_DATA1][N-1:0];
    assign port_cmd = cmd == CMD_CONNECT || cmd == CMD_POWER ||
                      cmd == CMD_DISABLE || cmd == CMD_DATA_LINE;
    assign busy_out = state_q != EX_IDLE;

    // Buffer writes are refused while a command runs; no arbitration needed
    assign bus_we = bus_wr && wb_adr_in == WB_DATA && wb_sel_in[0] &&
                    ptr_q != OP_EXEC && in_range && !busy_out;
    assign start  = bus_wr && wb_adr_in == WB_DATA && wb_sel_in[0] &&
                    ptr_q == OP_EXEC && wb_dat_in[7:0] == EXEC_TERM &&
                    !busy_out;

    assign buf_we   = ex_we || bus_we;
    assign buf_addr = ex_we ? ex_addr : ptr_q[BUF_AW-1:0];
    assign buf_data = ex_we ? ex_data : wb_dat_in[7:0];

    seh_buffer u_buf (
        .clk_in    (clk_in),
        .rstn_in   (rstn_in),
        .we_in     (buf_we),
        .waddr_in  (buf_addr),
        .wdata_in  (buf_data),
        .raddr_in  (ptr_q[BUF_AW-1:0]),
        .rdata_out (rdata),
        .head_out  (head)
    );

    seh_port_fmt #(.N(N)) u_fmt (
        .cmd_in   (cmd),
        .stat_in  (port_stat_in),
        .byte_out (fmt)
    );

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= bus_req;
            rdat_q <= 32'h0000_0000;
            if (bus_rd) begin
                unique case (wb_adr_in)
                    WB_PTR:  rdat_q <= {16'h0000, ptr_q};
                    WB_DATA: rdat_q <= {24'h000000, first_q ? READ_COUNT :
                                        (in_range ? rdata : 8'h00)};
                    WB_ADDR: rdat_q <= {25'h0000000, addr_q};
                    WB_STAT: rdat_q <= {23'h000000, busy_out, status_q};
                    default: rdat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_ack_out = ack_q;
    assign wb_dat_out = rdat_q;

    // Pointer and read-phase tracking
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            ptr_q   <= 16'h0000;
            first_q <= 1'b1;
        end else if (bus_wr && wb_adr_in == WB_PTR &&
                     wb_sel_in[1:0] == 2'b11) begin
            ptr_q   <= wb_dat_in[15:0];
            first_q <= 1'b1;
        end else if (bus_wr && wb_adr_in == WB_STOP) begin
            first_q <= 1'b1;
        end else if (bus_rd && wb_adr_in == WB_DATA) begin
            if (first_q) begin
                first_q <= 1'b0;
            end else begin
                ptr_q <= ptr_q + 16'h0001;
            end
        end else if (bus_we) begin
            ptr_q <= ptr_q + 16'h0001;
        end
    end

    // Strap is caught on the first cycle after reset release
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            dflt_q       <= SLV_ADDR_A;
            addr_q       <= SLV_ADDR_A;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            dflt_q       <= addr_strap_in ? SLV_ADDR_B : SLV_ADDR_A;
            addr_q       <= addr_strap_in ? SLV_ADDR_B : SLV_ADDR_A;
            strap_done_q <= 1'b1;
        end else if (state_q == EX_DECODE && cmd == CMD_SET_ADDR) begin
            if (head[OFS_DATA1][SA_RESTORE_BIT]) begin
                addr_q <= dflt_q;
            end else begin
                addr_q <= head[OFS_DATA1][6:0];
            end
        end
    end

    assign slave_addr_out = addr_q;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            port_dis_out <= '0;
        end else if (state_q == EX_PORTS && cmd == CMD_DISABLE &&
                     mask[idx_q] &&
                     head[OFS_DATA2 + {4'h0, idx_q}][PD_APPLY_BIT]) begin
            port_dis_out[idx_q] <= head[OFS_DATA2 + {4'h0, idx_q}][2:0];
        end
    end

    always_comb begin
        ex_we   = 1'b0;
        ex_addr = OFS_DATA1;
        ex_data = 8'h00;
        unique case (state_q)
            EX_DECODE: begin
                unique case (cmd)
                    CMD_GET_DFLT: begin
                        ex_we   = 1'b1;
                        ex_data = DFLT_REPORT;
                    end
                    CMD_HUB_INFO: begin
                        ex_we   = 1'b1;
                        ex_data = {hub_configured_in,
                                   legacy_hub_bus_addr_in};
                    end
                    CMD_CC_MASK: begin
                        ex_we   = 1'b1;
                        ex_data = 8'(charge_controller_present_in);
                    end
                    default: ex_we = 1'b0;
                endcase
            end
            EX_PORTS: begin
                ex_we   = cmd != CMD_DISABLE && mask[idx_q];
                ex_addr = OFS_DATA2 + {4'h0, idx_q};
                ex_data = fmt[idx_q];
            end
            EX_CC_WAIT: begin
                ex_we   = cc_rd_ack_in;
                ex_addr = OFS_DATA2;
                ex_data = cc_rd_data_in;
            end
            EX_STATUS: begin
                ex_we   = 1'b1;
                ex_addr = OFS_STAT;
                ex_data = status_q;
            end
            EX_IDLE: ex_we = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            state_q  <= EX_IDLE;
            idx_q    <= 3'd0;
            status_q <= 8'h00;
            wait_q   <= 16'h0000;
            req_q    <= 1'b0;
            ccad_q   <= 8'h00;
        end else begin
            unique case (state_q)
                EX_IDLE: begin
                    if (start) begin
                        state_q <= EX_DECODE;
                    end
                end
                EX_DECODE: begin
                    idx_q    <= 3'd0;
                    status_q <= ST_OK;
                    if (port_cmd) begin
                        state_q <= EX_PORTS;
                    end else if (cmd == CMD_CC_READ) begin
                        req_q   <= 1'b1;
                        ccad_q  <= head[OFS_DATA1];
                        wait_q  <= 16'(CC_WAIT);
                        state_q <= EX_CC_WAIT;
                    end else begin
                        if (cmd > CMD_CC_MASK) begin
                            status_q <= ST_ERR;
                        end
                        state_q <= EX_STATUS;
                    end
                end
                EX_PORTS: begin
                    idx_q <= idx_q + 3'd1;
                    if (idx_q == 3'(N - 1)) begin
                        state_q <= EX_STATUS;
                    end
                end
                EX_CC_WAIT: begin
                    wait_q <= wait_q - 16'h0001;
                    if (cc_rd_ack_in) begin
                        req_q   <= 1'b0;
                        state_q <= EX_STATUS;
                    end else if (wait_q == 16'h0000) begin
                        // Absent controller must not hang the engine
                        req_q    <= 1'b0;
                        status_q <= ST_ERR;
                        state_q  <= EX_STATUS;
                    end
                end
                EX_STATUS: begin
                    state_q <= EX_IDLE;
                end
            endcase
        end
    end

    assign cc_rd_req_out  = req_q;
    assign cc_rd_addr_out = ccad_q;
endmodule

// *** src/seh_pkg.sv ***
// Constants and carrier types for the extended hub command engine.
// Assumes a single 200 MHz clock domain and classic Wishbone access.
package seh_pkg;
    localparam int NPORT = 5;
    localparam int BUF_DEPTH = 128;
    localparam int BUF_AW = 7;
    localparam int CC_WAIT_CYC = 1024;

    localparam logic [15:0] OP_EXEC = 16'h993e;
    localparam logic [7:0] EXEC_TERM = 8'h00;
    localparam logic [7:0] READ_COUNT = 8'h80;

    localparam logic [BUF_AW-1:0] OFS_CMD = 7'h00;
    localparam logic [BUF_AW-1:0] OFS_STAT = 7'h01;
    localparam logic [BUF_AW-1:0] OFS_DATA1 = 7'h02;
    localparam logic [BUF_AW-1:0] OFS_DATA2 = 7'h03;
    localparam logic [BUF_AW-1:0] OFS_RESULT = 7'h04;

    localparam logic [7:0] CMD_SET_ADDR = 8'h00;
    localparam logic [7:0] CMD_GET_DFLT = 8'h01;
    localparam logic [7:0] CMD_HUB_INFO = 8'h02;
    localparam logic [7:0] CMD_CC_MASK = 8'h03;
    localparam logic [7:0] CMD_CONNECT = 8'h80;
    localparam logic [7:0] CMD_POWER = 8'h81;
    localparam logic [7:0] CMD_DISABLE = 8'h82;
    localparam logic [7:0] CMD_DATA_LINE = 8'h83;
    localparam logic [7:0] CMD_CC_READ = 8'h84;

    localparam logic [6:0] SLV_ADDR_A = 7'h2c;
    localparam logic [6:0] SLV_ADDR_B = 7'h2d;
    localparam logic [7:0] DFLT_REPORT = 8'h2d;

    localparam int SA_RESTORE_BIT = 7;
    localparam int INFO_CFG_BIT = 7;
    localparam int PD_APPLY_BIT = 7;
    localparam int CS_LSLEEP_BIT = 5;
    localparam int CS_SSLEEP_BIT = 4;
    localparam int CS_LATT_BIT = 1;
    localparam int CS_SSATT_BIT = 0;
    localparam int DL_MINUS_BIT = 1;
    localparam int DL_PLUS_BIT = 0;

    localparam logic [7:0] ST_OK = 8'h01;
    localparam logic [7:0] ST_ERR = 8'h02;

    localparam logic [7:0] WB_PTR = 8'h00;
    localparam logic [7:0] WB_DATA = 8'h04;
    localparam logic [7:0] WB_STOP = 8'h08;
    localparam logic [7:0] WB_ADDR = 8'h0c;
    localparam logic [7:0] WB_STAT = 8'h10;

    typedef struct packed {
        logic legacy_port_sleep_flag;
        logic superspeed_port_sleep_flag;
        logic legacy_attach_flag;
        logic superspeed_attach_flag;
        logic power_on;
        logic minus_line_high;
        logic plus_line_high;
    } seh_port_stat_t;

    typedef struct packed {
        logic force_off;
        logic superspeed_termination_off;
        logic legacy_termination_off;
    } seh_port_dis_t;

    typedef enum logic [2:0] {
        EX_IDLE, EX_DECODE, EX_PORTS, EX_CC_WAIT, EX_STATUS
    } seh_state_t;
endpackage

// *** src/seh_buffer.sv ***
// Command buffer: byte-wide flip-flop storage, one write port.
// Assumes the caller arbitrates writers; reads are combinational.
`timescale 1ns/100ps
module seh_buffer import seh_pkg::*; #(
    parameter int DEPTH = BUF_DEPTH,
    parameter int AW    = BUF_AW
) (
    input  wire logic          clk_in,
    input  wire logic          rstn_in,
    input  wire logic          we_in,
    input  wire logic [AW-1:0] waddr_in,
    input  wire logic [7:0]    wdata_in,
    input  wire logic [AW-1:0] raddr_in,
    output logic [7:0]         rdata_out,
    output logic [7:0][7:0]    head_out
);
    logic [DEPTH-1:0][7:0] mem_q;

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_ent
            always_ff @(posedge clk_in) begin
                if (!rstn_in) begin
                    mem_q[i] <= 8'h00;
                end else if (we_in && waddr_in == AW'(i)) begin
                    mem_q[i] <= wdata_in;
                end
            end
        end
        for (i = 0; i < 8; i++) begin : g_head
            assign head_out[i] = mem_q[i];
        end
    endgenerate

    assign rdata_out = mem_q[raddr_in];
endmodule

// *** src/seh_port_fmt.sv ***
// Per-port result byte formatter for the port status commands.
// Assumes status inputs are stable while a command runs.
`timescale 1ns/100ps
module seh_port_fmt import seh_pkg::*; #(
    parameter int N = NPORT
) (
    input  wire logic [7:0]             cmd_in,
    input  wire seh_port_stat_t [N-1:0] stat_in,
    output logic [N-1:0][7:0]           byte_out
);
    genvar p;
    generate
        for (p = 0; p < N; p++) begin : g_port
            always_comb begin
                byte_out[p] = 8'h00;
                unique case (cmd_in)
                    CMD_CONNECT: begin
                        byte_out[p][CS_LSLEEP_BIT] =
                            stat_in[p].legacy_port_sleep_flag;
                        byte_out[p][CS_SSLEEP_BIT] =
                            stat_in[p].superspeed_port_sleep_flag;
                        byte_out[p][CS_LATT_BIT] =
                            stat_in[p].legacy_attach_flag;
                        byte_out[p][CS_SSATT_BIT] =
                            stat_in[p].superspeed_attach_flag;
                    end
                    CMD_POWER: begin
                        byte_out[p][0] = stat_in[p].power_on;
                    end
                    CMD_DATA_LINE: begin
                        byte_out[p][DL_MINUS_BIT] =
                            stat_in[p].minus_line_high;
                        byte_out[p][DL_PLUS_BIT] =
                            stat_in[p].plus_line_high;
                    end
                    default: begin
                        byte_out[p] = 8'h00;
                    end
                endcase
            end
        end
    endgenerate
endmodule

// *** sim/seh_cc_model.sv ***
// Charge controller model answering register reads from the engine.
// Assumes the engine holds its read request until it is answered.
`timescale 1ns/100ps
module seh_cc_model (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       req_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [3:0] delay_in,
    input  wire logic       mute_in,
    output logic            ack_out,
    output logic [7:0]      data_out
);
    logic [3:0] wait_q;
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            wait_q   <= 4'h0;
            ack_out  <= 1'b0;
            data_out <= 8'h00;
        end else if (req_in && !ack_out && !mute_in && wait_q >= delay_in) begin
            wait_q   <= 4'h0;
            ack_out  <= 1'b1;
            data_out <= addr_in ^ 8'h3c;
        end else begin
            wait_q   <= (req_in && !ack_out) ? wait_q + 4'h1 : 4'h0;
            ack_out  <= 1'b0;
            // Data only valid in the reply cycle
            data_out <= ~data_out;
        end
    end
endmodule

// *** sim/seh_cmd_engine_sva.sv ***
// Port checker for the extended hub command engine.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/100ps
module seh_cmd_engine_sva import seh_pkg::*; #(
    parameter int N       = NPORT,
    parameter int CC_WAIT = CC_WAIT_CYC
) (
    input wire logic                  clk_in,
    input wire logic                  rstn_in,
    input wire logic                  wb_cyc_in,
    input wire logic                  wb_stb_in,
    input wire logic                  wb_we_in,
    input wire logic [31:0]           wb_dat_out,
    input wire logic                  wb_ack_out,
    input wire seh_port_dis_t [N-1:0] port_dis_out,
    input wire logic [6:0]            slave_addr_out,
    input wire logic                  cc_rd_req_out,
    input wire logic [7:0]            cc_rd_addr_out,
    input wire logic                  cc_rd_ack_in,
    input wire logic                  busy_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    logic [1:0] run_q;
    int         busy_q;
    // Skips the strap capture just after reset
    always_ff @(posedge clk_in) begin
        run_q <= rstn_in ? {run_q[0], 1'b1} : 2'b00;
    end
    always_ff @(posedge clk_in) begin
        busy_q <= (rstn_in && busy_out) ? busy_q + 1 : 0;
    end
    a_ack_timely: assert property (wb_cyc_in && wb_stb_in &&
        !wb_ack_out |=> wb_ack_out) else $error("bus request not answered");
    a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    a_dat_quiet: assert property (!wb_ack_out || wb_we_in
        |-> wb_dat_out == 32'h0) else $error("read data outside read");
    a_cc_addr_hold: assert property (cc_rd_req_out &&
        $past(cc_rd_req_out) |-> $stable(cc_rd_addr_out))
        else $error("cc address moved");
    a_cc_req_drop: assert property (cc_rd_req_out && cc_rd_ack_in
        |=> !cc_rd_req_out) else $error("cc request held after ack");
    a_dis_when_busy: assert property (run_q[1] &&
        $changed(port_dis_out) |-> $past(busy_out))
        else $error("disable moved while idle");
    a_addr_when_busy: assert property (run_q[1] &&
        $changed(slave_addr_out) |-> $past(busy_out))
        else $error("address moved while idle");
    a_busy_bounded: assert property (busy_q <= CC_WAIT + 16)
        else $error("command never completes");
    c_cc_read: cover property (cc_rd_req_out && cc_rd_ack_in);
    c_exec: cover property ($rose(busy_out));
    c_dis: cover property (run_q[1] && $changed(port_dis_out));
endmodule
bind seh_cmd_engine seh_cmd_engine_sva #(.N(N), .CC_WAIT(CC_WAIT)) sva_u (
    .clk_in(clk_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .port_dis_out(port_dis_out),
    .slave_addr_out(slave_addr_out), .cc_rd_req_out(cc_rd_req_out),
    .cc_rd_addr_out(cc_rd_addr_out), .cc_rd_ack_in(cc_rd_ack_in),
    .busy_out(busy_out));

// *** sim/tb.sv ***
// Self-checking bench for the extended hub command engine.
// Assumes ack one cycle after each Wishbone request.
`timescale 1ns/100ps
module tb import seh_pkg::*;;
    logic                       clk_in = 1'b0;
    logic                       rstn_in = 1'b0;
    logic                       cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]                 adr = 8'h00;
    logic [31:0]                wdat = 32'h0, rdat, dout;
    logic                       ack, busy, req, cack, cfg = 1'b0;
    logic                       mute = 1'b0;
    logic [6:0]                 haddr = 7'h00, saddr;
    logic [NPORT-1:0]           ccp = '0;
    seh_port_stat_t [NPORT-1:0] stat = '0;
    seh_port_dis_t [NPORT-1:0]  dis, dis_exp = '0;
    logic [7:0]                 caddr, cdata, b, m;
    logic [3:0]                 dly = 4'h0;
    logic [7:0]                 pc[6] = '{8'h80, 8'h81, 8'h83,
                                          8'h80, 8'h81, 8'h83};
    logic [7:0]                 d[$];
    int                         failures = 0, check_count = 0;
    always #2.5 clk_in = ~clk_in;
    seh_cmd_engine #(.CC_WAIT(16)) dut_u (
        .clk_in(clk_in), .rstn_in(rstn_in), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(dout),
        .wb_ack_out(ack), .addr_strap_in(1'b1),
        .hub_configured_in(cfg), .legacy_hub_bus_addr_in(haddr),
        .charge_controller_present_in(ccp), .port_stat_in(stat),
        .port_dis_out(dis), .slave_addr_out(saddr),
        .cc_rd_req_out(req), .cc_rd_addr_out(caddr),
        .cc_rd_ack_in(cack), .cc_rd_data_in(cdata), .busy_out(busy));
    seh_cc_model cc_u (
        .clk_in(clk_in), .rstn_in(rstn_in), .req_in(req),
        .addr_in(caddr), .delay_in(dly), .mute_in(mute),
        .ack_out(cack), .data_out(cdata));
    task automatic give_verdict();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic hang();
        failures++;
        $display("mismatch at %0t: wait ran out", $time);
        give_verdict();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_dis(input seh_port_dis_t got, exp);
        chk({29'h0, got}, {29'h0, exp});
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] v);
        int i;
        @(posedge clk_in);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= v;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_in);
            if (ack === 1'b1) break;
        end
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (i == 20) hang();
    endtask
    task automatic get(input logic [6:0] off);
        xfer(1'b1, WB_PTR, {25'h0, off});
        xfer(1'b0, WB_DATA, 32'h0);
        chk(rdat, {24'h0, READ_COUNT});
        xfer(1'b0, WB_DATA, 32'h0);
    endtask
    task automatic run(input logic [7:0] q[$], input logic [7:0] st);
        int i;
        xfer(1'b1, WB_PTR, 32'h0);
        foreach (q[k]) xfer(1'b1, WB_DATA, {24'h0, q[k]});
        xfer(1'b1, WB_PTR, {16'h0, OP_EXEC});
        xfer(1'b1, WB_DATA, {24'h0, EXEC_TERM});
        for (i = 0; i < 60; i++) begin
            xfer(1'b0, WB_STAT, 32'h0);
            if (rdat[8] === 1'b0) break;
        end
        if (i == 60) hang();
        chk({31'h0, busy}, 32'h0);
        get(OFS_STAT);
        chk(rdat, {24'h0, st});
    endtask
    function automatic logic [7:0] port_byte(logic [7:0] c,
                                             seh_port_stat_t s);
        case (c)
            CMD_CONNECT: port_byte = {2'b00, s.legacy_port_sleep_flag,
                s.superspeed_port_sleep_flag, 2'b00,
                s.legacy_attach_flag, s.superspeed_attach_flag};
            CMD_POWER: port_byte = {7'h00, s.power_on};
            default: port_byte = {6'h00, s.minus_line_high,
                s.plus_line_high};
        endcase
    endfunction
    initial begin
        void'($urandom(32'hd6b5689d));
        repeat (16) @(posedge clk_in);
        rstn_in <= 1'b1;
        xfer(1'b0, WB_ADDR, 32'h0);
        chk(rdat, {25'h0, SLV_ADDR_B});
        chk({25'h0, saddr}, {25'h0, SLV_ADDR_B});
        xfer(1'b0, 8'h14, 32'h0);
        chk(rdat, 32'h0);
        b = {1'b0, 7'($urandom)};
        run('{CMD_SET_ADDR, 8'h00, b}, ST_OK);
        xfer(1'b0, WB_ADDR, 32'h0);
        chk(rdat, {24'h0, b});
        chk({25'h0, saddr}, {24'h0, b});
        run('{CMD_GET_DFLT, 8'h00}, ST_OK);
        get(OFS_DATA1);
        chk(rdat, {24'h0, DFLT_REPORT});
        xfer(1'b1, WB_STOP, 32'h0);
        xfer(1'b0, WB_DATA, 32'h0);
        chk(rdat, {24'h0, READ_COUNT});
        run('{CMD_SET_ADDR, 8'h00, b | 8'h80}, ST_OK);
        xfer(1'b0, WB_ADDR, 32'h0);
        chk(rdat, {25'h0, SLV_ADDR_B});
        $display("test address done");
        for (int k = 0; k < 2; k++) begin
            cfg   <= k[0];
            haddr <= 7'($urandom);
            ccp   <= 5'($urandom);
            run('{CMD_HUB_INFO, 8'h00}, ST_OK);
            get(OFS_DATA1);
            chk(rdat, {24'h0, cfg, haddr});
            run('{CMD_CC_MASK, 8'h00}, ST_OK);
            get(OFS_DATA1);
            chk(rdat, {27'h0, ccp});
        end
        $display("test info done");
        foreach (pc[j]) begin
            stat <= (7*NPORT)'({$urandom, $urandom});
            m = (j == 0) ? 8'hff : 8'($urandom);
            xfer(1'b1, WB_PTR, {25'h0, OFS_DATA2});
            repeat (NPORT) xfer(1'b1, WB_DATA, 32'ha5);
            run('{pc[j], 8'h00, m}, ST_OK);
            for (int n = 0; n < NPORT; n++) begin
                get(OFS_DATA2 + 7'(n));
                b = m[n] ? port_byte(pc[j], stat[n]) : 8'ha5;
                chk(rdat, 32'(b));
            end
        end
        $display("test port status done");
        for (int r = 0; r < 4; r++) begin
            m = (r == 0) ? 8'hff : 8'($urandom);
            d = {};
            for (int n = 0; n < NPORT; n++) begin
                b = 8'($urandom);
                if (r == 0) b[7] = 1'b1;
                d.push_back(b);
                if (m[n] && b[7]) dis_exp[n] = b[2:0];
            end
            run('{CMD_DISABLE, 8'h00, m, d[0], d[1], d[2], d[3], d[4]},
                ST_OK);
            foreach (dis_exp[n]) begin
                chk_dis(dis[n], dis_exp[n]);
            end
        end
        $display("test disable done");
        for (int r = 0; r < 3; r++) begin
            mute <= (r == 2);
            dly  <= {1'b0, 3'($urandom)};
            b = 8'($urandom);
            run('{CMD_CC_READ, 8'h00, b, 8'h00}, (r == 2) ? ST_ERR : ST_OK);
            get(OFS_DATA2);
            chk(rdat, {24'h0, (r < 2) ? b ^ 8'h3c : 8'h00});
        end
        mute <= 1'b0;
        run('{8'h85, 8'h00}, ST_ERR);
        $display("test cc read done");
        give_verdict();
    end
endmodule
